// ---- rtl/aiac_ctrl.sv ----
// Acquisition control: parameter records, modes, recorder and interrupts
//
// Overview of operation
// - Cycle time is factor times 100 us, factor up to 600, any channel count.
// - Factor zero selects a 25 us cycle time.
// - While recording, the cycle time is the sample storing interval.
// - Writing cycle, mode or trigger record stops a running recording.
// - Mode bits 5..1 decode standard, end-of-cycle, scope 1/2/4/8 channels, FIFO.
// - Standard mode converts all eight channels each cycle as 16-bit values.
// - End-of-cycle mode raises an interrupt when a new value set is ready.
// - End-of-cycle interrupt only when cycle time is at least 200 us.
// - Diagnostic enable raises an interrupt on error appearing and on clearing.
// - Channel leaving its limit window raises a process interrupt if enabled.
// - Host acknowledges a process interrupt; the device clears it then.
// - No limit process interrupts in scope or FIFO mode.
// - Scope memory of 65536 values is split evenly over recorded channels.
// - FIFO mode records all eight channels, 8190 values per channel.
// - FIFO overflow wraps to the start and flags an overflow error.
// - Trigger channel from bits 2..0 of byte 0, rising or falling edge.
// - Manual start ignores trigger channel, pre-trigger and level.
// - Pre-trigger percent in byte 1 bits 6..0, 00h to 64h.
// - Signed trigger level in bytes 2,3, range 8100h to 7EFFh, crossing triggers.
// - Trigger condition 00 rising, 01 falling, 10 manual start.
// - Scope data is readable only once the buffer is full.
// - Per-channel upper and lower limits, default 7FFFh and 8000h.
// - Diagnostics of every channel disabled after power-on.
// - Start request code 01h starts recording or arms edge monitoring; in the full state the code only returns to idle.
module aiac_ctrl
    import aiac_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic         rec_wr,
    input  wire logic [7:0]   rec_num,
    input  wire logic [39:0]  rec_data,
    input  wire logic         start_req,
    input  wire logic [7:0]   start_code,
    input  wire logic [127:0] sample_data,
    input  wire logic         conv_error,
    input  wire logic [7:0]   proc_ack,
    input  wire logic         rd_req,
    input  wire logic [2:0]   rd_chan,
    input  wire logic [15:0]  rd_index,
    output logic              cycle_tick,
    output logic              eoc_irq,
    output logic              diag_irq,
    output logic              diag_going,
    output logic [7:0]        proc_irq,
    output logic [1:0]        rec_state,
    output logic              fifo_overflow,
    output logic              data_ready,
    output logic [15:0]       rd_data,
    output logic [15:0]       rec_count
);
    import aiac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding
    function automatic aiac_op_e decode_op(input logic [4:0] code);
        unique case (code)
            5'b00000: decode_op = AIAC_OP_STD;
            5'b00010: decode_op = AIAC_OP_STD_EOC;
            5'b00100, 5'b01000, 5'b01100, 5'b10000: decode_op = AIAC_OP_SCOPE;
            5'b00001: decode_op = AIAC_OP_FIFO;
            default:  decode_op = AIAC_OP_STD;
        endcase
    endfunction

    // Log2 of recorded channel count for scope mode
    function automatic logic [1:0] scope_shift(input logic [4:0] code);
        unique case (code)
            5'b01000: scope_shift = 2'd1;
            5'b01100: scope_shift = 2'd2;
            5'b10000: scope_shift = 2'd3;
            5'b00001: scope_shift = 2'd3;
            default:  scope_shift = 2'd0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Parameter records
    logic [15:0] mode_q, mode_d;
    logic [15:0] cycle_q, cycle_d;
    logic [39:0] trig_q, trig_d;
    logic [15:0] upper_q [8];
    logic [15:0] lower_q [8];
    logic        param_stop;

    always_comb begin
        mode_d     = mode_q;
        cycle_d    = cycle_q;
        trig_d     = trig_q;
        param_stop = 1'b0;
        if (rec_wr) begin
            unique case (rec_num)
                AIAC_REC_MODE:  begin mode_d  = rec_data[15:0]; param_stop = 1'b1; end
                AIAC_REC_CYCLE: begin cycle_d = rec_data[15:0]; param_stop = 1'b1; end
                AIAC_REC_TRIG:  begin trig_d  = rec_data;       param_stop = 1'b1; end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q  <= AIAC_MODE_RST;
            cycle_q <= AIAC_CYCLE_RST;
            trig_q  <= AIAC_TRIG_RST;
        end else begin
            mode_q  <= mode_d;
            cycle_q <= cycle_d;
            trig_q  <= trig_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_lim
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    upper_q[g] <= AIAC_LIM_UPPER_RST;
                    lower_q[g] <= AIAC_LIM_LOWER_RST;
                end else if (rec_wr && rec_num == AIAC_REC_LIMIT_BASE + 8'(g)) begin
                    upper_q[g] <= rec_data[15:0];
                    lower_q[g] <= rec_data[31:16];
                end
            end
        end
    endgenerate

    aiac_op_e    op;
    logic [1:0]  shift;
    logic [2:0]  trig_chan;
    logic [6:0]  pre_pct;
    logic [15:0] trig_level;
    aiac_tc_e    trig_cond;
    logic        recording_mode;

    always_comb begin
        op             = decode_op(mode_q[AIAC_MODE_MSB:AIAC_MODE_LSB]);
        shift          = scope_shift(mode_q[AIAC_MODE_MSB:AIAC_MODE_LSB]);
        trig_chan      = trig_q[2:0];
        pre_pct        = (trig_q[14:8] > AIAC_PRE_MAX) ? AIAC_PRE_MAX : trig_q[14:8];
        trig_level     = trig_q[31:16];
        if ($signed(trig_level) < $signed(AIAC_LEVEL_MIN)) begin
            trig_level = AIAC_LEVEL_MIN;
        end else if ($signed(trig_level) > $signed(AIAC_LEVEL_MAX)) begin
            trig_level = AIAC_LEVEL_MAX;
        end
        trig_cond      = (trig_q[33:32] == 2'b11) ? AIAC_TC_MANUAL : aiac_tc_e'(trig_q[33:32]);
        recording_mode = (op == AIAC_OP_SCOPE) || (op == AIAC_OP_FIFO);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle timer
    aiac_cycle_timer u_timer (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .factor  (cycle_q),
        .restart (param_stop),
        .tick    (cycle_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Standard conversion, end of cycle, limits, diagnostics
    logic [15:0] sample [8];
    logic [7:0]  out_win;
    logic [7:0]  proc_q, proc_d;
    logic        err_q, err_d;
    logic        eoc_d, dia_d, dgo_d;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            sample[i]  = sample_data[16*i +: 16];
            out_win[i] = ($signed(sample[i]) > $signed(upper_q[i]))
                      || ($signed(sample[i]) < $signed(lower_q[i]));
        end
        proc_d = proc_q & ~proc_ack;
        if (cycle_tick && !recording_mode) begin
            proc_d = proc_d | (out_win & mode_q[AIAC_LIMEN_LSB +: 8]);
        end
        eoc_d = cycle_tick && (op == AIAC_OP_STD_EOC)
             && (cycle_q >= AIAC_EOC_MIN_FACT);
        err_d = conv_error;
        dia_d = mode_q[AIAC_DIAG_EN] && (conv_error != err_q);
        dgo_d = mode_q[AIAC_DIAG_EN] && err_q && !conv_error;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            proc_q     <= 8'h00;
            err_q      <= 1'b0;
            eoc_irq    <= 1'b0;
            diag_irq   <= 1'b0;
            diag_going <= 1'b0;
        end else begin
            proc_q     <= proc_d;
            err_q      <= err_d;
            eoc_irq    <= eoc_d;
            diag_irq   <= dia_d;
            diag_going <= dgo_d;
        end
    end

    assign proc_irq = proc_q;

    ////////////////////////////////////////////////////////////////////////////
    // Recorder
    logic [15:0] mem [AIAC_MEM_WORDS];
    aiac_st_e    st_q, st_d;
    logic [15:0] wptr_q, wptr_d;   // Next write position within each channel partition, wraps
    logic [16:0] post_q, post_d;   // Samples left after trigger
    logic [15:0] prev_q;
    logic        ovf_q, ovf_d;
    logic [16:0] per_chan;
    logic [16:0] pre_cnt;
    logic [15:0] depth;
    logic [15:0] tval;
    logic        trig_hit;
    logic        store;
    logic [3:0]  nch;

    always_comb begin
        per_chan = 17'(AIAC_MEM_WORDS) >> shift;
        depth    = (op == AIAC_OP_FIFO) ? 16'(AIAC_FIFO_DEPTH) : 16'(per_chan - 17'd1);
        pre_cnt  = 17'((32'(per_chan) * 32'(pre_pct)) / 32'd100);
        nch      = (op == AIAC_OP_FIFO) ? 4'd8 : 4'(4'd1 << shift);
        tval     = sample[trig_chan];
        trig_hit = (trig_cond == AIAC_TC_RISE)
                 ? ($signed(prev_q) < $signed(trig_level) && $signed(tval) >= $signed(trig_level))
                 : ($signed(prev_q) > $signed(trig_level) && $signed(tval) <= $signed(trig_level));
        st_d   = st_q;
        wptr_d = wptr_q;
        post_d = post_q;
        ovf_d  = ovf_q;
        store  = 1'b0;
        unique case (st_q)
            AIAC_ST_IDLE: begin
                if (start_req && start_code == AIAC_START_CODE && recording_mode) begin
                    wptr_d = 16'd0;
                    ovf_d  = 1'b0;
                    post_d = (trig_cond == AIAC_TC_MANUAL) ? per_chan : per_chan - pre_cnt;
                    st_d   = (op == AIAC_OP_SCOPE && trig_cond != AIAC_TC_MANUAL)
                           ? AIAC_ST_ARMED : AIAC_ST_REC;
                end
            end
            AIAC_ST_ARMED: begin
                if (cycle_tick) begin
                    store  = 1'b1;
                    wptr_d = (wptr_q == 16'(per_chan - 17'd1)) ? 16'd0 : wptr_q + 16'd1;
                    if (trig_hit) begin
                        st_d = AIAC_ST_REC;
                    end
                end
            end
            AIAC_ST_REC: begin
                if (cycle_tick) begin
                    store = 1'b1;
                    if (op == AIAC_OP_FIFO) begin
                        if (wptr_q == depth - 16'd1) begin
                            wptr_d = 16'd0;
                            ovf_d  = 1'b1;
                        end else begin
                            wptr_d = wptr_q + 16'd1;
                        end
                    end else begin
                        wptr_d = (wptr_q == 16'(per_chan - 17'd1)) ? 16'd0 : wptr_q + 16'd1;
                        post_d = post_q - 17'd1;
                        if (post_q <= 17'd1) begin
                            st_d = AIAC_ST_FULL;
                        end
                    end
                end
            end
            AIAC_ST_FULL: begin
                if (start_req && start_code == AIAC_START_CODE) begin
                    st_d = AIAC_ST_IDLE;
                end
            end
        endcase
        if (param_stop) begin
            st_d = AIAC_ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_q   <= AIAC_ST_IDLE;
            wptr_q <= 16'd0;
            post_q <= 17'd0;
            prev_q <= 16'd0;
            ovf_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            wptr_q <= wptr_d;
            post_q <= post_d;
            ovf_q  <= ovf_d;
            if (cycle_tick) begin
                prev_q <= tval;
            end
        end
    end

    // Sample memory, channel-major partitions
    always_ff @(posedge ref_clk) begin
        if (store) begin
            for (int c = 0; c < 8; c++) begin
                if (4'(c) < nch) begin
                    mem[16'((32'(c) * 32'(per_chan)) + 32'(wptr_q))] <= sample[c];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readout
    logic        readable;
    logic [15:0] rd_addr;

    always_comb begin
        readable = (op == AIAC_OP_FIFO) || (st_q == AIAC_ST_FULL);
        rd_addr  = 16'((32'(rd_chan) * 32'(per_chan)) + 32'(rd_index));
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 16'h0000;
        end else if (rd_req && readable && 4'(rd_chan) < nch) begin
            rd_data <= mem[rd_addr];
        end
    end

    assign rec_state     = st_q;
    assign fifo_overflow = ovf_q;
    assign data_ready    = readable && recording_mode;
    assign rec_count     = wptr_q;
endmodule

// ---- rtl/aiac_cycle_timer.sv ----
// Cycle timer: emits one tick per conversion cycle
module aiac_cycle_timer
    import aiac_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic [15:0] factor,
    input  wire logic        restart,
    output logic             tick
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [31:0] period;

    always_comb begin
        if (factor == 16'h0000) begin
            period = AIAC_FAST_CYC;
        end else if (factor > AIAC_FACTOR_MAX) begin
            period = 32'(AIAC_FACTOR_MAX) * AIAC_BASE_CYC;
        end else begin
            period = 32'(factor) * AIAC_BASE_CYC;
        end
        tick  = (cnt_q >= period - 32'd1);
        cnt_d = (tick || restart) ? 32'd0 : cnt_q + 32'd1;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 32'd0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// ---- rtl/aiac_pkg.sv ----
// Package: constants and types for the analog input acquisition control
package aiac_pkg;
    // Record set numbers (register offsets)
    localparam logic [7:0] AIAC_REC_LIMIT_BASE = 8'ha0;
    localparam logic [7:0] AIAC_REC_LIMIT_LAST = 8'ha7;
    localparam logic [7:0] AIAC_REC_CYCLE      = 8'ha8;
    localparam logic [7:0] AIAC_REC_MODE       = 8'h7f;
    localparam logic [7:0] AIAC_REC_TRIG       = 8'hbe;

    // Reset values
    localparam logic [15:0] AIAC_CYCLE_RST     = 16'h0001;
    localparam logic [15:0] AIAC_MODE_RST      = 16'h0000;
    localparam logic [39:0] AIAC_TRIG_RST      = 40'h0000000000;
    localparam logic [15:0] AIAC_LIM_UPPER_RST = 16'h7fff;
    localparam logic [15:0] AIAC_LIM_LOWER_RST = 16'h8000;

    // Mode byte field positions
    localparam int AIAC_MODE_LSB  = 1;
    localparam int AIAC_MODE_MSB  = 5;
    localparam int AIAC_DIAG_EN   = 6;
    localparam int AIAC_LIMEN_LSB = 8;

    // Cycle time
    localparam int          AIAC_CLK_MHZ       = 100;
    localparam int          AIAC_BASE_US       = 100;
    localparam int          AIAC_FAST_US       = 25;
    localparam int          AIAC_EOC_MIN_US    = 200;
    localparam logic [15:0] AIAC_FACTOR_MAX    = 16'd600;
    localparam logic [15:0] AIAC_EOC_MIN_FACT  = 16'(AIAC_EOC_MIN_US / AIAC_BASE_US);
    localparam logic [31:0] AIAC_BASE_CYC      = 32'(AIAC_BASE_US * AIAC_CLK_MHZ);
    localparam logic [31:0] AIAC_FAST_CYC      = 32'(AIAC_FAST_US * AIAC_CLK_MHZ);

    // Memory sizes, pre-trigger and trigger level limits
    localparam int          AIAC_MEM_WORDS     = 65536;
    localparam logic [12:0] AIAC_FIFO_DEPTH    = 13'd8190;
    localparam logic [6:0]  AIAC_PRE_MAX       = 7'h64;
    localparam logic [15:0] AIAC_LEVEL_MIN     = 16'h8100;
    localparam logic [15:0] AIAC_LEVEL_MAX     = 16'h7eff;

    // Start request code
    localparam logic [7:0]  AIAC_START_CODE    = 8'h01;

    typedef enum logic [2:0] {
        AIAC_OP_STD     = 3'b000,
        AIAC_OP_STD_EOC = 3'b001,
        AIAC_OP_SCOPE   = 3'b010,
        AIAC_OP_FIFO    = 3'b011
    } aiac_op_e;

    typedef enum logic [1:0] {
        AIAC_TC_RISE   = 2'b00,
        AIAC_TC_FALL   = 2'b01,
        AIAC_TC_MANUAL = 2'b10
    } aiac_tc_e;

    typedef enum logic [1:0] {
        AIAC_ST_IDLE  = 2'b00,
        AIAC_ST_ARMED = 2'b01,
        AIAC_ST_REC   = 2'b10,
        AIAC_ST_FULL  = 2'b11
    } aiac_st_e;
endpackage

// ---- tb/aiac_ctrl_checker.sv ----
// Checker: port-level properties of the acquisition control
module aiac_ctrl_checker
    import aiac_pkg::*;
(
    input wire logic         ref_clk,
    input wire logic         resetn,
    input wire logic         rec_wr,
    input wire logic [7:0]   rec_num,
    input wire logic [39:0]  rec_data,
    input wire logic         start_req,
    input wire logic [7:0]   start_code,
    input wire logic [7:0]   proc_ack,
    input wire logic         cycle_tick,
    input wire logic         eoc_irq,
    input wire logic         diag_irq,
    input wire logic         diag_going,
    input wire logic [7:0]   proc_irq,
    input wire logic [1:0]   rec_state,
    input wire logic         data_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mode_q, mode_d, fac_q, fac_d;
    logic [31:0] cnt_q, cnt_d, per;
    logic [2:0]  en_q, en_d;
    logic [7:0]  lim_en;
    logic [4:0]  op;
    logic        ok_q, ok_d, rec_m, sc, eoc_ok, restart;
    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        restart = rec_wr && (rec_num == AIAC_REC_CYCLE || rec_num == AIAC_REC_MODE
            || rec_num == AIAC_REC_TRIG);
        mode_d = mode_q;
        fac_d = fac_q;
        if (rec_wr && rec_num == AIAC_REC_MODE) mode_d = rec_data[15:0];
        if (rec_wr && rec_num == AIAC_REC_CYCLE) fac_d = rec_data[15:0];
        cnt_d = cycle_tick ? 32'h0 : cnt_q + 32'h1;
        ok_d = (ok_q || cycle_tick) && !restart;
        en_d = {en_q[1:0], mode_q[6]};
        op = mode_q[5:1];
        lim_en = mode_q[15:8];
        sc = op == 5'b00100 || op == 5'b01000 || op == 5'b01100 || op == 5'b10000;
        rec_m = sc || op == 5'b00001;
        eoc_ok = op == 5'b00010 && fac_q >= AIAC_EOC_MIN_FACT;
        per = (fac_q == 16'h0) ? AIAC_FAST_CYC : AIAC_BASE_CYC *
            ((fac_q > AIAC_FACTOR_MAX) ? 32'(AIAC_FACTOR_MAX) : 32'(fac_q));
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= AIAC_MODE_RST;
            fac_q  <= AIAC_CYCLE_RST;
            cnt_q  <= 32'h0;
            en_q   <= 3'h0;
            ok_q   <= 1'b0;
        end else begin
            mode_q <= mode_d;
            fac_q  <= fac_d;
            cnt_q  <= cnt_d;
            en_q   <= en_d;
            ok_q   <= ok_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence s_start_ok;
        start_req && start_code == AIAC_START_CODE && rec_m && rec_state == 2'd0 && !rec_wr;
    endsequence
    a_tick_period: assert property (
        cycle_tick && ok_q |-> cnt_q == per - 32'h1) else $error("Cycle tick spacing wrong");
    a_tick_late: assert property (
        ok_q |-> cnt_q < per) else $error("Cycle tick missing");
    a_eoc_on_tick: assert property (
        cycle_tick && eoc_ok |=> eoc_irq) else $error("End of cycle interrupt missing");
    a_eoc_needs_slow: assert property (
        eoc_irq |-> $past(cycle_tick) && $past(eoc_ok)) else $error("Stray end of cycle pulse");
    a_diag_enabled: assert property (
        diag_irq |-> (en_q != 3'h0 || mode_q[6])) else $error("Diagnostic pulse while disabled");
    a_going_is_diag: assert property (
        diag_going |-> diag_irq) else $error("Going event without diagnostic pulse");
    a_stop_on_write: assert property (
        restart |=> rec_state == 2'd0) else $error("Recording not stopped by record write");
    a_limit_rise: assert property (
        (proc_irq & ~$past(proc_irq)) != 8'h00 |-> $past(cycle_tick) && !$past(rec_m)
            && (proc_irq & ~$past(proc_irq) & ~$past(lim_en)) == 8'h00)
        else $error("Process interrupt without cause");
    a_ack_clears: assert property (
        proc_ack != 8'h00 && !cycle_tick |=> (proc_irq & $past(proc_ack)) == 8'h00)
        else $error("Acknowledge did not clear interrupt");
    a_ready_full: assert property (
        sc |-> data_ready == (rec_state == 2'd3)) else $error("Data ready not tied to full");
    a_start_arms: assert property (
        s_start_ok |=> rec_state != 2'd0) else $error("Start request not taken");
    a_start_refused: assert property (
        start_req && (start_code != AIAC_START_CODE || !rec_m) && rec_state == 2'd0 && !rec_wr
            |=> rec_state == 2'd0) else $error("Illegal start request taken");
endmodule
bind aiac_ctrl aiac_ctrl_checker u_chk (
    .ref_clk, .resetn, .rec_wr, .rec_num, .rec_data, .start_req, .start_code, .proc_ack,
    .cycle_tick, .eoc_irq, .diag_irq, .diag_going, .proc_irq, .rec_state, .data_ready
);

// ---- tb/aiac_host_model.sv ----
// Host model: services process interrupts and acknowledges them on handler exit
module aiac_host_model (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] proc_irq,
    output logic      [7:0] proc_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] busy_q;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_q   <= 3'h0;
            proc_ack <= 8'h00;
        end else begin
            proc_ack <= 8'h00;
            if (proc_irq != 8'h00 && proc_ack == 8'h00) busy_q <= busy_q + 3'h1;
            if (busy_q == 3'h4) begin
                proc_ack <= proc_irq;
                busy_q   <= 3'h0;
            end
        end
    end
endmodule

// ---- tb/testbench.sv ----
// Testbench: host record writes and start requests against the acquisition control
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import aiac_pkg::*;
    logic            ref_clk, resetn, rec_wr, start_req, conv_error, rd_req;
    logic [7:0]      rec_num, start_code;
    logic [39:0]     rec_data;
    logic [127:0]    sample_data;
    wire logic [7:0] proc_ack, proc_irq;
    wire logic       cycle_tick, eoc_irq, diag_irq, diag_going, fifo_overflow, data_ready;
    wire logic [1:0] rec_state;
    wire logic [15:0] rd_data, rec_count;
    int              n_mismatch, n_compared, n_diag, n_going, n_eoc, per;
    logic [15:0]     modes [5] = '{16'h0008, 16'h0010, 16'h0018, 16'h0020, 16'h0002};
    localparam logic [15:0] DIAG_ON = 16'h0040;
    aiac_ctrl uut (
        .ref_clk, .resetn, .rec_wr, .rec_num, .rec_data, .start_req, .start_code,
        .sample_data, .conv_error, .proc_ack, .rd_req, .rd_chan(3'h0),
        .rd_index(16'h0000), .cycle_tick, .eoc_irq, .diag_irq, .diag_going, .proc_irq,
        .rec_state, .fifo_overflow, .data_ready, .rd_data, .rec_count
    );
    aiac_host_model u_host (.ref_clk, .resetn, .proc_irq, .proc_ack);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] num, input logic [39:0] data);
        @(posedge ref_clk);
        rec_wr   <= 1'b1;
        rec_num  <= num;
        rec_data <= data;
        @(posedge ref_clk);
        rec_wr   <= 1'b0;
    endtask
    task automatic start(input logic [7:0] code);
        @(posedge ref_clk);
        start_req  <= 1'b1;
        start_code <= code;
        @(posedge ref_clk);
        start_req  <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] exp);
        @(posedge ref_clk);
        rd_req <= 1'b1;
        @(posedge ref_clk);
        rd_req <= 1'b0;
        @(negedge ref_clk);
        chk(40'(rd_data), 40'(exp));
    endtask
    task automatic err(input logic v);
        @(posedge ref_clk);
        conv_error <= v;
        repeat (6) @(negedge ref_clk);
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            if (n > 20000) begin
                n_mismatch++;
                close_out();
            end
        end while (cycle_tick !== 1'b1);
        @(posedge ref_clk);
    endtask
    task automatic wait_state(input logic [1:0] st);
        int i;
        for (i = 0; i < 12000 && rec_state !== st; i++) @(negedge ref_clk);
        if (i == 12000) begin
            n_mismatch++;
            close_out();
        end
    endtask
    always @(posedge ref_clk) begin
        if (diag_irq === 1'b1) n_diag++;
        if (diag_going === 1'b1) n_going++;
        if (eoc_irq === 1'b1) n_eoc++;
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        rec_wr = 1'b0;
        start_req = 1'b0;
        rd_req = 1'b0;
        conv_error = 1'b0;
        rec_num = 8'h00;
        start_code = 8'h00;
        rec_data = 40'h0;
        sample_data = 128'h0;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        err(1'b1);
        err(1'b0);
        chk(40'(n_diag), 40'd0);
        wr(AIAC_REC_MODE, 40'(DIAG_ON));
        err(1'b1);
        err(1'b0);
        chk(40'(n_diag), 40'd2);
        chk(40'(n_going), 40'd1);
        $display("Test diagnostics done");
        wait_tick(per);
        wait_tick(per);
        chk(40'(per), 40'd10000);
        wr(AIAC_REC_CYCLE, 40'd2);
        wr(AIAC_REC_MODE, 40'(DIAG_ON | 16'h0004));
        wait_tick(per);
        repeat (3) @(negedge ref_clk);
        chk(40'(n_eoc), 40'd1);
        wr(AIAC_REC_CYCLE, 40'd1);
        wait_tick(per);
        repeat (3) @(negedge ref_clk);
        chk(40'(n_eoc), 40'd1);
        wr(AIAC_REC_CYCLE, 40'd0);
        wait_tick(per);
        wait_tick(per);
        chk(40'(per), 40'd2500);
        $display("Test cycle time done");
        wr(AIAC_REC_LIMIT_BASE, 40'h00ff000100);
        wr(AIAC_REC_LIMIT_BASE + 8'h01, 40'h00ff000100);
        wr(AIAC_REC_MODE, 40'(DIAG_ON | 16'h0500));
        @(posedge ref_clk);
        sample_data <= {80'h0, 16'h7fff, 16'h0200, 16'h0200};
        wait_tick(per);
        @(negedge ref_clk);
        chk(proc_irq, 8'h01);
        repeat (10) @(negedge ref_clk);
        chk(proc_irq, 8'h00);
        $display("Test limits done");
        wr(AIAC_REC_TRIG, 40'h0001006403);
        wr(AIAC_REC_MODE, 40'(DIAG_ON | 16'h0520));
        wait_tick(per);
        repeat (2) @(negedge ref_clk);
        chk(proc_irq, 8'h00);
        start(8'h00);
        repeat (2) @(negedge ref_clk);
        chk(rec_state, 2'd0);
        start(AIAC_START_CODE);
        wait_tick(per);
        @(negedge ref_clk);
        chk(rec_state, 2'd1);
        chk(data_ready, 1'b0);
        @(posedge ref_clk);
        sample_data[63:48] <= 16'h0200;
        wait_state(2'd3);
        chk(data_ready, 1'b1);
        rd(16'h0200);
        chk(40'(rec_count), 40'd3);
        wr(AIAC_REC_TRIG, 40'h0101006403);
        @(negedge ref_clk);
        chk(rec_state, 2'd0);
        start(AIAC_START_CODE);
        wait_tick(per);
        @(posedge ref_clk);
        sample_data[63:48] <= 16'h0000;
        wait_state(2'd3);
        $display("Test edge trigger done");
        wr(AIAC_REC_TRIG, 40'h027eff6407);
        foreach (modes[i]) begin
            wr(AIAC_REC_MODE, 40'(DIAG_ON | modes[i]));
            start(AIAC_START_CODE);
            wait_tick(per);
            @(negedge ref_clk);
            chk(rec_state, 2'd2);
            if (i[0]) wr(AIAC_REC_MODE, 40'(DIAG_ON | modes[i]));
            else wr(AIAC_REC_CYCLE, 40'd0);
            @(negedge ref_clk);
            chk(rec_state, 2'd0);
        end
        $display("Test manual start done");
        wr(AIAC_REC_MODE, 40'(DIAG_ON | 16'h0002));
        start(AIAC_START_CODE);
        wait_tick(per);
        repeat (2) @(negedge ref_clk);
        chk(rec_state, 2'd2);
        chk(fifo_overflow, 1'b0);
        wr(AIAC_REC_MODE, 40'(DIAG_ON | 16'h003e));
        start(AIAC_START_CODE);
        wait_tick(per);
        repeat (3) @(negedge ref_clk);
        chk(rec_state, 2'd0);
        chk(40'(n_eoc), 40'd1);
        $display("Test fifo and unlisted mode done");
        close_out();
    end
endmodule
